/* design/dio_pkg.sv */
/*
  constants, field layouts and types for the outbound direct i/o request engine.
  assumes a single clock and one register port reaching all register sets.
*/
// Contract
// - all direct reads, writes, doorbells leave here
// - check xoff for destination and priority
// - dma read only after flow and fifo grant
// - blocked flow: no packet, interrupt, code 010
// - blocked set stays busy until service release
// - packets leave buffer in completion order
// - highest priority first in fifos on retry
// - shared buffers, state machine assigns free slots
// - dma request carries buffer address, response fills
// - interleaved segments, one payload done per cycle
// - forward after last byte, then free buffer
// - sixteen payload slots plus sixteen header slots
// - two-port buffer memory 128 bits wide
// - buffer space shared with other outgoing sources
// - posted write releases once header is stored
// - blocked posted write flags, releases after service
// - non-posted stays busy until response code set
// - test-and-swap payload judged locally, not forwarded
// - read builds header-only packet, no payload slot
// - no receive buffer reserved before read sent
// - every request goes to selected output port
// - command write starts, busy next cycle, locked
// - three-bit completion code meanings
// - four independent register sets on one port
package dio_pkg;
  // register index within a set; byte address is set*32 + index*4
  localparam logic [2:0] IDX_REMOTE_ADDR = 3'h0;
  localparam logic [2:0] IDX_LOCAL_ADDR = 3'h1;
  localparam logic [2:0] IDX_BYTE_COUNT = 3'h2;
  localparam logic [2:0] IDX_ROUTE = 3'h3;
  localparam logic [2:0] IDX_COMMAND = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  localparam int SET_STRIDE_LSB = 5;
  // field positions
  localparam int ROUTE_DEST_LSB = 0;
  localparam int ROUTE_PRIO_LSB = 16;
  localparam int ROUTE_PORT_LSB = 18;
  localparam int ROUTE_IRQ_BIT = 20;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_DBELL_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CODE_LSB = 1;
  localparam int STAT_RELEASE_BIT = 0;
  // buffer geometry
  localparam int MAX_PAYLOAD_BYTES = 256;
  localparam int BEAT_BYTES = 16;
  localparam int BEATS_PER_SLOT = MAX_PAYLOAD_BYTES / BEAT_BYTES;
  // completion codes
  localparam logic [2:0] CC_SUCCESS = 3'h0;
  localparam logic [2:0] CC_TIMEOUT = 3'h1;
  localparam logic [2:0] CC_XOFF = 3'h2;
  localparam logic [2:0] CC_ERR_RSP = 3'h3;
  localparam logic [2:0] CC_INVALID = 3'h4;
  localparam logic [2:0] CC_DMA_ERR = 3'h5;
  localparam logic [2:0] CC_RETRY_BUSY = 3'h6;
  localparam logic [2:0] CC_NO_CREDIT = 3'h7;
  // request kinds in the command register
  localparam logic [3:0] KIND_WRITE = 4'h0;
  localparam logic [3:0] KIND_WRITE_RSP = 4'h1;
  localparam logic [3:0] KIND_READ = 4'h2;
  localparam logic [3:0] KIND_DOORBELL = 4'h3;
  localparam logic [3:0] KIND_SWAP = 4'h4;
  // response status from the receive side
  localparam logic [1:0] RSP_DONE = 2'h0;
  localparam logic [1:0] RSP_ERROR = 2'h1;
  localparam logic [1:0] RSP_RETRY = 2'h2;
  localparam logic [1:0] RSP_TIMEOUT = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_FLOW, ST_RSP, ST_HOLD} dio_state_e;

  typedef struct packed {
    logic [31:0] remote_addr;
    logic [15:0] dest_id;
    logic [15:0] doorbell_info;
    logic [12:0] byte_count;
    logic [3:0] kind;
    logic [1:0] flow_prio;
    logic [1:0] port;
    logic [1:0] set_id;
    logic [40:0] spare;
  } dio_hdr_s;
endpackage

/* design/dio_tx_engine.sv */
/*
  outbound request engine: four register sets, flow check, shared transmit
  buffer, dma payload fetch, forwarding to the tx fifos and response handling.
  assumes all inputs synchronous to i_ref_clk and dma tags below 16.
*/
`timescale 1ns/100ps
module dio_tx_engine #(
  parameter int NUM_SETS = 4,
  parameter int NUM_PORTS = 4,
  parameter int DATA_W = 128,
  parameter int PAY_SLOTS = 16,
  parameter int NOPAY_SLOTS = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic [15:0] o_fc_dest_id,
  output logic [1:0] o_fc_priority,
  input wire logic i_fc_xoff,
  input wire logic [NUM_PORTS-1:0] i_port_free,
  output logic o_fifo_alloc,
  output logic [1:0] o_fifo_alloc_port,
  output logic o_dma_req,
  output logic [31:0] o_dma_addr,
  output logic [12:0] o_dma_bytes,
  output logic [4:0] o_dma_tag,
  input wire logic i_dma_gnt,
  input wire logic i_dma_rvalid,
  input wire logic [4:0] i_dma_rtag,
  input wire logic [DATA_W-1:0] i_dma_rdata,
  input wire logic i_dma_rlast,
  input wire logic i_dma_rerr,
  output logic o_tx_valid,
  output logic [DATA_W-1:0] o_tx_data,
  output logic o_tx_sop,
  output logic o_tx_eop,
  output logic [1:0] o_tx_port,
  output logic [1:0] o_tx_priority,
  input wire logic i_tx_ready,
  input wire logic i_rsp_valid,
  input wire logic [1:0] i_rsp_set,
  input wire logic [1:0] i_rsp_status,
  input wire logic [63:0] i_rsp_data,
  output logic [NUM_SETS-1:0] o_irq_set,
  output logic [NUM_SETS-1:0] o_busy
);
  localparam int SLOTS = PAY_SLOTS + NOPAY_SLOTS;
  localparam int SLOT_W = $clog2(SLOTS);
  localparam int SET_W = $clog2(NUM_SETS);
  localparam int BEAT_W = $clog2(dio_pkg::BEATS_PER_SLOT) + 1;
  localparam int PAY_W = $clog2(PAY_SLOTS);
  localparam int BIDX_W = $clog2(dio_pkg::BEATS_PER_SLOT);
  function automatic logic has_payload(input logic [3:0] kind);
    has_payload = (kind == dio_pkg::KIND_WRITE) || (kind == dio_pkg::KIND_WRITE_RSP) ||
                  (kind == dio_pkg::KIND_SWAP);
  endfunction

  function automatic logic is_posted(input logic [3:0] kind);
    is_posted = (kind == dio_pkg::KIND_WRITE);
  endfunction

  logic [31:0] remote_addr [NUM_SETS];
  logic [31:0] local_addr [NUM_SETS];
  logic [12:0] byte_count [NUM_SETS];
  logic [20:0] route [NUM_SETS];
  logic [31:0] command [NUM_SETS];
  logic [2:0] code [NUM_SETS];
  dio_pkg::dio_state_e state [NUM_SETS];
  logic [SLOT_W-1:0] set_slot [NUM_SETS];

  logic [DATA_W-1:0] pay_mem [PAY_SLOTS*dio_pkg::BEATS_PER_SLOT];
  dio_pkg::dio_hdr_s hdr_mem [SLOTS];
  logic [SLOTS-1:0] slot_used;
  logic [BEAT_W-1:0] slot_beats [SLOTS];
  logic [SET_W-1:0] slot_owner [SLOTS];
  logic [BIDX_W-1:0] wr_beat [PAY_SLOTS];
  logic [PAY_SLOTS-1:0] slot_err;

  // completion-ordered queue of ready slots
  logic [SLOT_W-1:0] q_mem [SLOTS];
  logic [SLOT_W:0] q_wp;
  logic [SLOT_W:0] q_rp;

  logic [SET_W-1:0] rr_ptr;
  logic cand_valid;
  logic [SET_W-1:0] cand;
  logic cand_pay;
  logic [1:0] cand_port;
  logic pay_found;
  logic nopay_found;
  logic [SLOT_W-1:0] pay_idx;
  logic [SLOT_W-1:0] nopay_idx;
  logic grant;
  logic blocked;
  logic [SLOT_W-1:0] grant_slot;
  logic [SET_W-1:0] acc_set;
  logic [2:0] acc_idx;
  logic push_dma;
  logic push_hdr;
  logic dma_fail;
  logic [PAY_W-1:0] rtag;
  logic fwd_busy;
  logic [SLOT_W-1:0] fwd_slot;
  logic [BEAT_W-1:0] fwd_beat;
  logic tx_load;
  logic fwd_eop;

  assign acc_set = i_reg_addr[dio_pkg::SET_STRIDE_LSB +: SET_W];
  assign acc_idx = i_reg_addr[4:2];
  assign rtag = i_dma_rtag[PAY_W-1:0];

  always_comb begin
    o_fc_dest_id = route[cand][dio_pkg::ROUTE_DEST_LSB +: 16];
    o_fc_priority = route[cand][dio_pkg::ROUTE_PRIO_LSB +: 2];
  end

  always_comb begin
    logic [SET_W-1:0] idx;
    idx = '0;
    cand_valid = 1'b0;
    cand = '0;
    for (int i = 0; i < NUM_SETS; i++) begin
      idx = SET_W'(int'(rr_ptr) + i);
      if (!cand_valid && state[idx] == dio_pkg::ST_FLOW) begin
        cand_valid = 1'b1;
        cand = idx;
      end
    end
  end

  // payload slots low, header-only slots high
  always_comb begin
    pay_found = 1'b0;
    nopay_found = 1'b0;
    pay_idx = '0;
    nopay_idx = '0;
    for (int s = 0; s < SLOTS; s++) begin
      if (!slot_used[s] && s < PAY_SLOTS && !pay_found) begin
        pay_found = 1'b1;
        pay_idx = SLOT_W'(s);
      end
      if (!slot_used[s] && s >= PAY_SLOTS && !nopay_found) begin
        nopay_found = 1'b1;
        nopay_idx = SLOT_W'(s);
      end
    end
  end

  assign cand_pay = has_payload(command[cand][dio_pkg::CMD_KIND_LSB +: 4]);
  assign cand_port = route[cand][dio_pkg::ROUTE_PORT_LSB +: 2];
  // grant only with flow on, fifo room and a free slot
  assign blocked = cand_valid && i_fc_xoff;
  assign grant = cand_valid && !i_fc_xoff && i_port_free[cand_port] &&
                 (cand_pay ? (pay_found && !o_dma_req) : nopay_found);
  assign grant_slot = cand_pay ? pay_idx : nopay_idx;

  assign push_dma = i_dma_rvalid && i_dma_rlast && !i_dma_rerr && !slot_err[rtag];
  assign dma_fail = i_dma_rvalid && i_dma_rlast && (i_dma_rerr || slot_err[rtag]);
  assign push_hdr = grant && !cand_pay;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rr_ptr <= '0;
    end else if (cand_valid) begin
      rr_ptr <= SET_W'(int'(cand) + 1);
    end
  end

  // register writes, locked while busy
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int n = 0; n < NUM_SETS; n++) begin
        remote_addr[n] <= '0;
        local_addr[n] <= '0;
        byte_count[n] <= '0;
        route[n] <= '0;
        command[n] <= '0;
      end
    end else if (i_reg_wr && state[acc_set] == dio_pkg::ST_IDLE) begin
      case (acc_idx)
        dio_pkg::IDX_REMOTE_ADDR: remote_addr[acc_set] <= i_reg_wdata;
        dio_pkg::IDX_LOCAL_ADDR: local_addr[acc_set] <= i_reg_wdata;
        dio_pkg::IDX_BYTE_COUNT: byte_count[acc_set] <= i_reg_wdata[12:0];
        dio_pkg::IDX_ROUTE: route[acc_set] <= i_reg_wdata[20:0];
        dio_pkg::IDX_COMMAND: command[acc_set] <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_set <= '0;
      for (int n = 0; n < NUM_SETS; n++) begin
        state[n] <= dio_pkg::ST_IDLE;
        code[n] <= dio_pkg::CC_SUCCESS;
        set_slot[n] <= '0;
      end
    end else begin
      o_irq_set <= '0;
      for (int n = 0; n < NUM_SETS; n++) begin
        logic [3:0] kind;
        logic irq_req;
        kind = (i_reg_wr && acc_set == SET_W'(n) && acc_idx == dio_pkg::IDX_COMMAND &&
               state[n] == dio_pkg::ST_IDLE) ? i_reg_wdata[dio_pkg::CMD_KIND_LSB +: 4] :
               command[n][dio_pkg::CMD_KIND_LSB +: 4];
        irq_req = route[n][dio_pkg::ROUTE_IRQ_BIT];
        case (state[n])
          dio_pkg::ST_IDLE: begin
            if (i_reg_wr && acc_set == SET_W'(n) && acc_idx == dio_pkg::IDX_COMMAND) begin
              if (kind > dio_pkg::KIND_SWAP || (has_payload(kind) &&
                  (byte_count[n] == 13'h0 || byte_count[n] > 13'(dio_pkg::MAX_PAYLOAD_BYTES)))) begin
                code[n] <= dio_pkg::CC_INVALID;
                o_irq_set[n] <= 1'b1;
              end else begin
                state[n] <= dio_pkg::ST_FLOW;
              end
            end
          end
          dio_pkg::ST_FLOW: begin
            if (cand == SET_W'(n) && blocked) begin
              code[n] <= dio_pkg::CC_XOFF;
              o_irq_set[n] <= 1'b1;
              state[n] <= dio_pkg::ST_HOLD;
            end else if (cand == SET_W'(n) && grant) begin
              set_slot[n] <= grant_slot;
              code[n] <= dio_pkg::CC_SUCCESS;
              state[n] <= is_posted(kind) ? dio_pkg::ST_IDLE : dio_pkg::ST_RSP;
            end
          end
          dio_pkg::ST_RSP: begin
            if (i_rsp_valid && i_rsp_set == SET_W'(n)) begin
              logic [2:0] c;
              c = dio_pkg::CC_SUCCESS;
              case (i_rsp_status)
                dio_pkg::RSP_DONE: c = (kind == dio_pkg::KIND_SWAP && i_rsp_data != 64'h0) ?
                                       dio_pkg::CC_RETRY_BUSY : dio_pkg::CC_SUCCESS;
                dio_pkg::RSP_ERROR: c = dio_pkg::CC_ERR_RSP;
                dio_pkg::RSP_RETRY: c = (kind == dio_pkg::KIND_DOORBELL) ?
                                        dio_pkg::CC_RETRY_BUSY : dio_pkg::CC_ERR_RSP;
                default: c = dio_pkg::CC_TIMEOUT;
              endcase
              code[n] <= c;
              o_irq_set[n] <= (c != dio_pkg::CC_SUCCESS) || irq_req;
              state[n] <= dio_pkg::ST_IDLE;
            end else if (dma_fail && slot_owner[rtag] == SET_W'(n) &&
                         set_slot[n] == SLOT_W'(rtag)) begin
              code[n] <= dio_pkg::CC_DMA_ERR;
              o_irq_set[n] <= 1'b1;
              state[n] <= dio_pkg::ST_HOLD;
            end
          end
          dio_pkg::ST_HOLD: begin
            if (i_reg_wr && acc_set == SET_W'(n) && acc_idx == dio_pkg::IDX_STATUS &&
                i_reg_wdata[dio_pkg::STAT_RELEASE_BIT]) begin
              state[n] <= dio_pkg::ST_IDLE;
            end
          end
          default: state[n] <= dio_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    for (int n = 0; n < NUM_SETS; n++) begin
      o_busy[n] = (state[n] != dio_pkg::ST_IDLE);
    end
  end

  // register read, one cycle later
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else begin
      o_reg_rdata <= '0;
      if (i_reg_rd && acc_idx == dio_pkg::IDX_STATUS) begin
        o_reg_rdata[dio_pkg::STAT_BUSY_BIT] <= o_busy[acc_set];
        if (state[acc_set] == dio_pkg::ST_IDLE || state[acc_set] == dio_pkg::ST_HOLD) begin
          o_reg_rdata[dio_pkg::STAT_CODE_LSB +: 3] <= code[acc_set];
        end
      end else if (i_reg_rd && state[acc_set] == dio_pkg::ST_IDLE) begin
        case (acc_idx)
          dio_pkg::IDX_REMOTE_ADDR: o_reg_rdata <= remote_addr[acc_set];
          dio_pkg::IDX_LOCAL_ADDR: o_reg_rdata <= local_addr[acc_set];
          dio_pkg::IDX_BYTE_COUNT: o_reg_rdata <= {19'h0, byte_count[acc_set]};
          dio_pkg::IDX_ROUTE: o_reg_rdata <= {11'h0, route[acc_set]};
          dio_pkg::IDX_COMMAND: o_reg_rdata <= command[acc_set];
          default: o_reg_rdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (grant) begin
      hdr_mem[grant_slot] <= '{remote_addr: remote_addr[cand],
        dest_id: route[cand][dio_pkg::ROUTE_DEST_LSB +: 16],
        doorbell_info: command[cand][dio_pkg::CMD_DBELL_LSB +: 16],
        byte_count: byte_count[cand],
        kind: command[cand][dio_pkg::CMD_KIND_LSB +: 4],
        flow_prio: route[cand][dio_pkg::ROUTE_PRIO_LSB +: 2],
        port: cand_port, set_id: 2'(cand), spare: '0};
      slot_owner[grant_slot] <= cand;
      slot_beats[grant_slot] <= cand_pay ?
        BEAT_W'((byte_count[cand] + 13'(dio_pkg::BEAT_BYTES - 1)) >> 4) : '0;
    end
    if (i_dma_rvalid) begin
      pay_mem[{rtag, wr_beat[rtag]}] <= i_dma_rdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_used <= '0;
      slot_err <= '0;
      for (int p = 0; p < PAY_SLOTS; p++) begin
        wr_beat[p] <= '0;
      end
    end else begin
      if (grant) begin
        slot_used[grant_slot] <= 1'b1;
        if (cand_pay) begin
          wr_beat[grant_slot[PAY_W-1:0]] <= '0;
          slot_err[grant_slot[PAY_W-1:0]] <= 1'b0;
        end
      end
      if (i_dma_rvalid) begin
        wr_beat[rtag] <= wr_beat[rtag] + 1'b1;
        if (i_dma_rerr && !i_dma_rlast) begin
          slot_err[rtag] <= 1'b1;
        end
      end
      if (dma_fail) begin
        slot_used[rtag] <= 1'b0;
      end
      if (tx_load && fwd_busy && fwd_eop) begin
        slot_used[fwd_slot] <= 1'b0;
      end
    end
  end

  // dma request names the buffer slot
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dma_req <= 1'b0;
      o_dma_addr <= '0;
      o_dma_bytes <= '0;
      o_dma_tag <= '0;
      o_fifo_alloc <= 1'b0;
      o_fifo_alloc_port <= '0;
    end else begin
      o_fifo_alloc <= grant;
      if (grant) begin
        o_fifo_alloc_port <= cand_port;
      end
      if (grant && cand_pay) begin
        o_dma_req <= 1'b1;
        o_dma_addr <= local_addr[cand];
        o_dma_bytes <= byte_count[cand];
        o_dma_tag <= 5'(grant_slot);
      end else if (i_dma_gnt) begin
        o_dma_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q_wp <= '0;
    end else begin
      if (push_dma) begin
        q_mem[q_wp[SLOT_W-1:0]] <= SLOT_W'(rtag);
      end
      if (push_hdr) begin
        q_mem[push_dma ? q_wp[SLOT_W-1:0] + 1'b1 : q_wp[SLOT_W-1:0]] <= grant_slot;
      end
      q_wp <= q_wp + (SLOT_W+1)'(push_dma) + (SLOT_W+1)'(push_hdr);
    end
  end

  assign tx_load = !o_tx_valid || i_tx_ready;
  assign fwd_eop = (fwd_beat == slot_beats[fwd_slot]);

  // each packet tagged with its output port
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      q_rp <= '0;
      fwd_busy <= 1'b0;
      fwd_slot <= '0;
      fwd_beat <= '0;
      o_tx_valid <= 1'b0;
      o_tx_data <= '0;
      o_tx_sop <= 1'b0;
      o_tx_eop <= 1'b0;
      o_tx_port <= '0;
      o_tx_priority <= '0;
    end else if (tx_load) begin
      o_tx_valid <= fwd_busy;
      if (fwd_busy) begin
        o_tx_data <= (fwd_beat == '0) ? hdr_mem[fwd_slot] :
          pay_mem[{fwd_slot[PAY_W-1:0], BIDX_W'(fwd_beat - 1'b1)}];
        o_tx_sop <= (fwd_beat == '0);
        o_tx_eop <= fwd_eop;
        o_tx_port <= hdr_mem[fwd_slot].port;
        o_tx_priority <= hdr_mem[fwd_slot].flow_prio;
        fwd_beat <= fwd_beat + 1'b1;
        if (fwd_eop) begin
          fwd_busy <= 1'b0;
        end
      end else if (q_rp != q_wp) begin
        fwd_busy <= 1'b1;
        fwd_slot <= q_mem[q_rp[SLOT_W-1:0]];
        fwd_beat <= '0;
        q_rp <= q_rp + 1'b1;
      end
    end
  end
endmodule

/* testbench/dio_tx_engine_asserts.sv */
/*
  port checker for the outbound request engine, bound to dio_tx_engine.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module dio_chk #(
  parameter int NUM_SETS = 4,
  parameter int NUM_PORTS = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_fc_xoff,
  input wire logic [NUM_PORTS-1:0] i_port_free,
  input wire logic o_fifo_alloc,
  input wire logic [1:0] o_fifo_alloc_port,
  input wire logic o_dma_req,
  input wire logic [31:0] o_dma_addr,
  input wire logic [4:0] o_dma_tag,
  input wire logic i_dma_gnt,
  input wire logic o_tx_valid,
  input wire logic o_tx_sop,
  input wire logic o_tx_eop,
  input wire logic i_tx_ready,
  input wire logic i_rsp_valid,
  input wire logic [1:0] i_rsp_set,
  input wire logic [NUM_SETS-1:0] o_busy
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_rd_idle;
    !$past(i_reg_rd) |-> o_reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_rd_busy;
    i_reg_rd && i_reg_addr[4:2] < 3'h5 && o_busy[i_reg_addr[6:5]] |=> o_reg_rdata == 32'h0;
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("busy set register readable");
  property p_cmd_busy;
    i_reg_wr && i_reg_addr[4:2] == dio_pkg::IDX_COMMAND
      && i_reg_wdata[3:0] == dio_pkg::KIND_READ |=> o_busy[$past(i_reg_addr[6:5])];
  endproperty
  a_cmd_busy: assert property (p_cmd_busy)
    else $error("busy missing after command");
  property p_xoff;
    i_fc_xoff |=> !o_fifo_alloc;
  endproperty
  a_xoff: assert property (p_xoff)
    else $error("allocation for blocked flow");
  property p_alloc_port;
    o_fifo_alloc |-> |($past(i_port_free) & (NUM_PORTS'(1) << o_fifo_alloc_port));
  endproperty
  a_alloc_port: assert property (p_alloc_port)
    else $error("allocation on full port");
  property p_dma_hold;
    o_dma_req && !i_dma_gnt |=> o_dma_req && $stable(o_dma_addr) && $stable(o_dma_tag);
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("dma request changed before grant");
  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_sop) && $stable(o_tx_eop);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx beat dropped while stalled");
  property p_rsp_done;
    i_rsp_valid && o_busy[i_rsp_set] |=> !o_busy[$past(i_rsp_set)];
  endproperty
  a_rsp_done: assert property (p_rsp_done)
    else $error("set still busy after response");
endmodule
bind dio_tx_engine dio_chk #(.NUM_SETS(NUM_SETS), .NUM_PORTS(NUM_PORTS)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_fc_xoff(i_fc_xoff),
  .i_port_free(i_port_free), .o_fifo_alloc(o_fifo_alloc),
  .o_fifo_alloc_port(o_fifo_alloc_port), .o_dma_req(o_dma_req), .o_dma_addr(o_dma_addr),
  .o_dma_tag(o_dma_tag), .i_dma_gnt(i_dma_gnt), .o_tx_valid(o_tx_valid), .o_tx_sop(o_tx_sop),
  .o_tx_eop(o_tx_eop), .i_tx_ready(i_tx_ready), .i_rsp_valid(i_rsp_valid),
  .i_rsp_set(i_rsp_set), .o_busy(o_busy));

/* testbench/dio_far_model.sv */
/*
  far side model: flow answer, fifo space, dma responder and tx sink.
  assumes requests taken on rising edges; stalls are random.
*/
`timescale 1ns/100ps
module dio_far_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_xoff_dest,
  input wire logic [15:0] i_fc_dest_id,
  output logic o_fc_xoff,
  output logic [3:0] o_port_free,
  input wire logic i_dma_req,
  input wire logic [12:0] i_dma_bytes,
  input wire logic [4:0] i_dma_tag,
  output logic o_dma_gnt,
  output logic o_dma_rvalid,
  output logic [4:0] o_dma_rtag,
  output logic [127:0] o_dma_rdata,
  output logic o_dma_rlast,
  output logic o_tx_ready
);
  int tags[$];
  int left[$];
  assign o_fc_xoff = i_fc_dest_id == i_xoff_dest;
  assign o_port_free = 4'hf;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dma_gnt <= 1'b0;
      o_dma_rvalid <= 1'b0;
      o_dma_rtag <= 5'h0;
      o_dma_rdata <= 128'h0;
      o_dma_rlast <= 1'b0;
      o_tx_ready <= 1'b0;
    end else begin
      if (i_dma_req && o_dma_gnt) begin
        tags.push_back(i_dma_tag);
        left.push_back((i_dma_bytes + 15) / 16);
      end
      o_dma_gnt <= i_dma_req && !o_dma_gnt && $urandom_range(1, 0) == 1;
      // idle data keeps changing
      o_dma_rdata <= {4{$urandom}};
      o_dma_rvalid <= 1'b0;
      o_dma_rtag <= 5'($urandom);
      o_dma_rlast <= 1'b0;
      if (tags.size() > 0 && $urandom_range(2, 0) != 0) begin
        o_dma_rvalid <= 1'b1;
        o_dma_rtag <= 5'(tags[0]);
        o_dma_rlast <= left[0] == 1;
        left[0]--;
        if (left[0] == 0) begin
          void'(tags.pop_front());
          void'(left.pop_front());
        end
      end
      o_tx_ready <= $urandom_range(3, 0) != 0;
    end
  end
endmodule

/* testbench/dio_tx_engine_bench.sv */
/*
  self-checking bench for dio_tx_engine with the far side model.
  assumes 25 MHz clock; expectations queued by the driver.
*/
`timescale 1ns/100ps
module dio_tx_engine_bench;
  logic clk = 1'b0, rst, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, rsp_v = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] rsp_set = 2'h0, rsp_st = 2'h0, fc_pr, ap, txp, txpr;
  logic [63:0] rsp_data = 64'h0;
  logic [15:0] fc_dest;
  logic xoff, alloc, dreq, gnt, rv, rlast, txv, sop, eop, txr;
  logic [3:0] pfree, irq, busy;
  logic [31:0] daddr;
  logic [12:0] dbytes;
  logic [4:0] dtag, rtag;
  logic [127:0] rdat, txd;
  logic [31:0] rq[$];
  logic [23:0] tq[$];
  int n_mismatch = 0, checks = 0, n_pkt = 0, base = 0;
  dio_pkg::dio_hdr_s hdr;
  logic [3:0] kinds[6] = '{4'h2, 4'h1, 4'h4, 4'h3, 4'h5, 4'h4};
  logic [1:0] sts[6] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0};
  logic [2:0] codes[6] = '{3'h3, 3'h1, 3'h6, 3'h6, 3'h4, 3'h0};
  dio_tx_engine dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_fc_dest_id(fc_dest),
    .o_fc_priority(fc_pr), .i_fc_xoff(xoff), .i_port_free(pfree), .o_fifo_alloc(alloc),
    .o_fifo_alloc_port(ap), .o_dma_req(dreq), .o_dma_addr(daddr), .o_dma_bytes(dbytes),
    .o_dma_tag(dtag), .i_dma_gnt(gnt), .i_dma_rvalid(rv), .i_dma_rtag(rtag),
    .i_dma_rdata(rdat), .i_dma_rlast(rlast), .i_dma_rerr(1'b0), .o_tx_valid(txv),
    .o_tx_data(txd), .o_tx_sop(sop), .o_tx_eop(eop), .o_tx_port(txp), .o_tx_priority(txpr),
    .i_tx_ready(txr), .i_rsp_valid(rsp_v), .i_rsp_set(rsp_set), .i_rsp_status(rsp_st),
    .i_rsp_data(rsp_data), .o_irq_set(irq), .o_busy(busy));
  dio_far_model u_far (.i_ref_clk(clk), .i_rst(rst), .i_xoff_dest(16'h0bad),
    .i_fc_dest_id(fc_dest), .o_fc_xoff(xoff), .o_port_free(pfree), .i_dma_req(dreq),
    .i_dma_bytes(dbytes), .i_dma_tag(dtag), .o_dma_gnt(gnt), .o_dma_rvalid(rv),
    .o_dma_rtag(rtag), .o_dma_rdata(rdat), .o_dma_rlast(rlast), .o_tx_ready(txr));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] ad(input logic [1:0] s, input logic [2:0] i);
    return {1'b0, s, i, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // what: 0 irq of set v, 1 packet count above v, 2 set v idle
  task automatic wait_for(input int what, input int v);
    int n;
    n = 0;
    while (n < 500 && !(what == 0 ? irq[v] : what == 1 ? n_pkt > v : !busy[v])) begin
      @(negedge clk);
      n++;
    end
    if (n == 500) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic run(input logic [1:0] s, input logic [15:0] dest, input logic [3:0] kind,
    input logic [12:0] nb);
    logic [1:0] p, pr;
    p = 2'($urandom_range(3, 0));
    pr = 2'($urandom_range(3, 0));
    wr_reg(ad(s, dio_pkg::IDX_REMOTE_ADDR), $urandom);
    wr_reg(ad(s, dio_pkg::IDX_LOCAL_ADDR), $urandom);
    wr_reg(ad(s, dio_pkg::IDX_BYTE_COUNT), {19'h0, nb});
    wr_reg(ad(s, dio_pkg::IDX_ROUTE), {12'h0, p, pr, dest});
    if (dest != 16'h0bad && kind <= dio_pkg::KIND_SWAP) tq.push_back({dest, kind, p, pr});
    base = n_pkt;
    wr_reg(ad(s, dio_pkg::IDX_COMMAND), {28'h0, kind});
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) chk(rdata, rq.pop_front());
    if (txv && txr && sop) begin
      hdr = dio_pkg::dio_hdr_s'(txd);
      chk({8'h0, hdr.dest_id, hdr.kind, txp, txpr}, tq.size() > 0 ? {8'h0, tq.pop_front()}
        : 32'hffffffff);
    end
    if (txv && txr && eop) n_pkt++;
  end
  initial begin
    rst = 1'b1;
    void'($urandom(55061));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) rd_reg(ad(2'(s), dio_pkg::IDX_STATUS), 32'h0);
    rd_reg(ad(2'h3, 3'h6), 32'h0);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      wait_for(2, 0);
      run(2'h0, 16'h1234 + 16'(i), dio_pkg::KIND_WRITE, i ? 13'($urandom_range(256, 1))
        : 13'h100);
    end
    wait_for(1, base);
    rd_reg(ad(2'h0, dio_pkg::IDX_STATUS), 32'h0);
    $display("posted write test done");
    run(2'h1, 16'h0bad, dio_pkg::KIND_READ, 13'h8);
    wait_for(0, 1);
    rd_reg(ad(2'h1, dio_pkg::IDX_STATUS), {28'h0, dio_pkg::CC_XOFF, 1'b1});
    rd_reg(ad(2'h1, dio_pkg::IDX_ROUTE), 32'h0);
    wr_reg(ad(2'h1, dio_pkg::IDX_STATUS), 32'h1);
    rd_reg(ad(2'h1, dio_pkg::IDX_STATUS), {28'h0, dio_pkg::CC_XOFF, 1'b0});
    $display("blocked flow test done");
    for (int k = 0; k < 6; k++) begin
      run(2'h2, 16'h0100 + 16'(k), kinds[k], 13'h8);
      if (kinds[k] > dio_pkg::KIND_SWAP) wait_for(0, 2);
      else begin
        wait_for(1, base);
        rd_reg(ad(2'h2, dio_pkg::IDX_STATUS), 32'h1);
        @(posedge clk);
        rsp_v <= 1'b1;
        rsp_set <= 2'h2;
        rsp_st <= sts[k];
        rsp_data <= {63'h0, k == 2};
        @(posedge clk);
        rsp_v <= 1'b0;
      end
      rd_reg(ad(2'h2, dio_pkg::IDX_STATUS), {28'h0, codes[k], 1'b0});
    end
    $display("non-posted test done");
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
